// >>> design/svm_pkg.sv
// types shared by the supply monitor design
package svm_pkg;

  // monitor activity, gray coded along off -> warmup -> watch
  typedef enum logic [1:0] {
    SVM_OFF    = 2'h0,
    SVM_WARMUP = 2'h1,
    SVM_WATCH  = 2'h3
  } svm_state_e;

  typedef logic [7:0] svm_byte_t;

endpackage

// >>> design/svm_regs.svh
// register map, field positions, reset values and timing of the monitor
`ifndef SVM_REGS_SVH
`define SVM_REGS_SVH

// control register address
`define SVM_CTRL_ADDR       16'hFF78
`define SVM_CTRL_RESET      8'h00
// control register fields
`define SVM_BIT_ENABLE      3'h7
`define SVM_BIT_MODE        3'h1
`define SVM_BIT_FLAG        3'h0
// mask flag value after external reset
`define SVM_MASK_RESET      1'h1
// comparator start-up time and clock period, in ns
`define SVM_WARMUP_NS       200000
`define SVM_CLK_PERIOD_NS   100

`endif

// >>> design/svm_supply_monitor.sv
// supply monitor control register, flag, interrupt and reset request

`include "svm_regs.svh"

module svm_supply_monitor #(
  parameter int WARMUP_CYCLES =
    (`SVM_WARMUP_NS + `SVM_CLK_PERIOD_NS - 1) / `SVM_CLK_PERIOD_NS
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST_B,
  input  wire logic       POWER_ON_CLEAR,
  input  wire logic       WATCHDOG_RESET,
  input  wire logic       SUPPLY_BELOW,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic       REG_BYTE_WR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_BIT_WR,
  input  wire logic [2:0] REG_BIT_SEL,
  input  wire logic       REG_BIT_VAL,
  input  wire logic       REG_RD,
  output logic [7:0]      REG_RDATA,
  input  wire logic       CAUSE_RD,
  input  wire logic       MASK_WR,
  input  wire logic       MASK_WDATA,
  output logic            SUPPLY_IRQ_MASK,
  output logic            SUPPLY_LOW_IRQ,
  output logic            SUPPLY_RST_REQ,
  output logic            SUPPLY_RESET_CAUSE_FLAG,
  output logic            COMPARATOR_ON,
  output logic            COMPARATOR_READY
);

  localparam int CW = $clog2(WARMUP_CYCLES + 1);

  // true when an access targets the control register
  function automatic logic ctrl_hit(input logic [15:0] addr);
    ctrl_hit = (addr == `SVM_CTRL_ADDR);
  endfunction

  logic                 below_sync;
  logic                 monitor_enable_r;
  logic                 monitor_enable_nxt;
  logic                 reset_mode_select_r;
  logic                 reset_mode_select_nxt;
  logic                 below_threshold_flag_r;
  logic                 below_threshold_flag_nxt;
  logic                 irq_r;
  logic                 irq_nxt;
  logic                 rst_req_r;
  logic                 rst_req_nxt;
  logic                 cause_r;
  logic                 cause_nxt;
  logic                 mask_r;
  logic                 mask_nxt;
  svm_pkg::svm_byte_t   rdata_r;
  svm_pkg::svm_byte_t   rdata_nxt;
  svm_pkg::svm_byte_t   ctrl_view;
  svm_pkg::svm_state_e  state_r;
  svm_pkg::svm_state_e  state_nxt;
  logic [CW-1:0]        warm_cnt_r;
  logic [CW-1:0]        warm_cnt_nxt;
  logic                 ready_r;
  logic                 ready_nxt;
  logic                 other_reset;

  // comparator level brought into the clock domain
  svm_sync3 u_sync (
    .CLK_SYS   (CLK_SYS),
    .RST_B     (RST_B),
    .async_in  (SUPPLY_BELOW),
    .level_out (below_sync)
  );

  // any reset source other than the monitor itself
  assign other_reset = !RST_B || POWER_ON_CLEAR || WATCHDOG_RESET;

  // control register as software sees it; reserved bits read zero
  always_comb begin
    ctrl_view = `SVM_CTRL_RESET;
    ctrl_view[`SVM_BIT_ENABLE] = monitor_enable_r;
    ctrl_view[`SVM_BIT_MODE] = reset_mode_select_r;
    ctrl_view[`SVM_BIT_FLAG] = below_threshold_flag_r;
  end

  // enable and mode bits: byte or single-bit writes, flag bit ignored
  always_comb begin
    monitor_enable_nxt = monitor_enable_r;
    reset_mode_select_nxt = reset_mode_select_r;
    if (REG_BYTE_WR && ctrl_hit(REG_ADDR)) begin
      monitor_enable_nxt = REG_WDATA[`SVM_BIT_ENABLE];
      reset_mode_select_nxt = REG_WDATA[`SVM_BIT_MODE];
    end else if (REG_BIT_WR && ctrl_hit(REG_ADDR)) begin
      if (REG_BIT_SEL == `SVM_BIT_ENABLE) begin
        monitor_enable_nxt = REG_BIT_VAL;
      end
      if (REG_BIT_SEL == `SVM_BIT_MODE) begin
        reset_mode_select_nxt = REG_BIT_VAL;
      end
    end
    if (other_reset) begin
      monitor_enable_nxt = 1'h0;
      reset_mode_select_nxt = 1'h0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    monitor_enable_r <= monitor_enable_nxt;
    reset_mode_select_r <= reset_mode_select_nxt;
  end

  // flag follows the comparator only while enabled
  always_comb begin
    below_threshold_flag_nxt = monitor_enable_r && below_sync;
    if (!RST_B) begin
      below_threshold_flag_nxt = 1'h0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    below_threshold_flag_r <= below_threshold_flag_nxt;
  end

  // interrupt and reset requests from the flag and the mode
  always_comb begin
    irq_nxt = 1'h0;
    rst_req_nxt = 1'h0;
    if (monitor_enable_r && !reset_mode_select_r) begin
      irq_nxt = below_threshold_flag_r;
    end
    if (monitor_enable_r && reset_mode_select_r) begin
      rst_req_nxt = below_threshold_flag_r;
    end
    if (other_reset) begin
      irq_nxt = 1'h0;
      rst_req_nxt = 1'h0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    irq_r <= irq_nxt;
    rst_req_r <= rst_req_nxt;
  end

  // reset-cause flag: set wins over a read clear; watchdog keeps it
  always_comb begin
    cause_nxt = cause_r;
    if (CAUSE_RD) begin
      cause_nxt = 1'h0;
    end
    if (rst_req_r) begin
      cause_nxt = 1'h1;
    end
    if (!RST_B || POWER_ON_CLEAR) begin
      cause_nxt = 1'h0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    cause_r <= cause_nxt;
  end

  // supply interrupt mask, set by the external reset input
  always_comb begin
    mask_nxt = mask_r;
    if (MASK_WR) begin
      mask_nxt = MASK_WDATA;
    end
    if (!RST_B) begin
      mask_nxt = `SVM_MASK_RESET;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    mask_r <= mask_nxt;
  end

  // read data, registered; unmapped addresses read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (REG_RD) begin
      rdata_nxt = ctrl_hit(REG_ADDR) ? ctrl_view : `SVM_CTRL_RESET;
    end
    if (!RST_B) begin
      rdata_nxt = `SVM_CTRL_RESET;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    rdata_r <= rdata_nxt;
  end

  // comparator start-up tracker; ready after the start-up time
  always_comb begin
    state_nxt = state_r;
    warm_cnt_nxt = warm_cnt_r;
    case (state_r)
      svm_pkg::SVM_OFF: begin
        warm_cnt_nxt = '0;
        if (monitor_enable_r) begin
          state_nxt = svm_pkg::SVM_WARMUP;
        end
      end
      svm_pkg::SVM_WARMUP: begin
        warm_cnt_nxt = warm_cnt_r + CW'(1);
        if (!monitor_enable_r) begin
          state_nxt = svm_pkg::SVM_OFF;
        end else if (warm_cnt_r == CW'(WARMUP_CYCLES - 1)) begin
          state_nxt = svm_pkg::SVM_WATCH;
        end
      end
      svm_pkg::SVM_WATCH: begin
        if (!monitor_enable_r) begin
          state_nxt = svm_pkg::SVM_OFF;
        end
      end
      default: begin
        state_nxt = svm_pkg::SVM_OFF;
      end
    endcase
    if (other_reset) begin
      state_nxt = svm_pkg::SVM_OFF;
      warm_cnt_nxt = '0;
    end
    // ready is registered so the output comes from a flip-flop
    ready_nxt = (state_nxt == svm_pkg::SVM_WATCH);
  end

  always_ff @(posedge CLK_SYS) begin
    state_r <= state_nxt;
    warm_cnt_r <= warm_cnt_nxt;
    ready_r <= ready_nxt;
  end

  // outputs straight from flip-flops
  assign REG_RDATA = rdata_r;
  assign SUPPLY_IRQ_MASK = mask_r;
  assign SUPPLY_LOW_IRQ = irq_r;
  assign SUPPLY_RST_REQ = rst_req_r;
  assign SUPPLY_RESET_CAUSE_FLAG = cause_r;
  assign COMPARATOR_ON = monitor_enable_r;
  assign COMPARATOR_READY = ready_r;

endmodule // svm_supply_monitor

// >>> design/svm_sync3.sv
// three-stage synchroniser with agreement filter for one async level
module svm_sync3 (
  input  wire logic CLK_SYS,
  input  wire logic RST_B,
  input  wire logic async_in,
  output logic      level_out
);

  logic [2:0] stage_r;
  logic [2:0] stage_nxt;
  logic       level_r;
  logic       level_nxt;

  // shift in; first stage feeds only the second
  always_comb begin
    stage_nxt = {stage_r[1:0], async_in};
    level_nxt = level_r;
    if (stage_r[1] == stage_r[2]) begin
      level_nxt = stage_r[2];
    end
    if (!RST_B) begin
      stage_nxt = 3'h0;
      level_nxt = 1'h0;
    end
  end

  // registers only
  always_ff @(posedge CLK_SYS) begin
    stage_r <= stage_nxt;
    level_r <= level_nxt;
  end

  assign level_out = level_r;

endmodule // svm_sync3

// >>> dv/svm_monitor.sv
// port assertions for the supply monitor
module svm_monitor (
  input wire logic        CLK_SYS,
  input wire logic        RST_B,
  input wire logic        POWER_ON_CLEAR,
  input wire logic        WATCHDOG_RESET,
  input wire logic [15:0] REG_ADDR,
  input wire logic        REG_BYTE_WR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic        REG_BIT_WR,
  input wire logic [2:0]  REG_BIT_SEL,
  input wire logic        REG_BIT_VAL,
  input wire logic        REG_RD,
  input wire logic [7:0]  REG_RDATA,
  input wire logic        CAUSE_RD,
  input wire logic        SUPPLY_LOW_IRQ,
  input wire logic        SUPPLY_RST_REQ,
  input wire logic        SUPPLY_RESET_CAUSE_FLAG,
  input wire logic        COMPARATOR_ON
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // write taken at the control address with no other reset source
  logic ok;
  assign ok = REG_ADDR == 16'hFF78 && !POWER_ON_CLEAR && !WATCHDOG_RESET;
  // request outputs against mode, enable and cause flag
  property p_irq_en; SUPPLY_LOW_IRQ |-> $past(COMPARATOR_ON); endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq while off");
  property p_excl; !(SUPPLY_LOW_IRQ && SUPPLY_RST_REQ); endproperty
  a_excl: assert property (p_excl) else $error("irq and reset");
  property p_cause_set;
    SUPPLY_RST_REQ && !POWER_ON_CLEAR |=> SUPPLY_RESET_CAUSE_FLAG;
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("cause");
  property p_cause_clr;
    CAUSE_RD && !SUPPLY_RST_REQ |=> !SUPPLY_RESET_CAUSE_FLAG;
  endproperty
  a_cause_clr: assert property (p_cause_clr) else $error("clr");
  property p_other_rst;
    POWER_ON_CLEAR || WATCHDOG_RESET |=> !COMPARATOR_ON && !SUPPLY_RST_REQ;
  endproperty
  a_other_rst: assert property (p_other_rst) else $error("rst");
  // register writes and reads
  property p_byte_en;
    REG_BYTE_WR && ok |=> COMPARATOR_ON == $past(REG_WDATA[7]);
  endproperty
  a_byte_en: assert property (p_byte_en) else $error("byte wr");
  property p_bit_en;
    REG_BIT_WR && !REG_BYTE_WR && ok && REG_BIT_SEL == 3'h7
      |=> COMPARATOR_ON == $past(REG_BIT_VAL);
  endproperty
  a_bit_en: assert property (p_bit_en) else $error("bit wr");
  property p_rd_resv; REG_RD |=> REG_RDATA[6:2] == 5'h00; endproperty
  a_rd_resv: assert property (p_rd_resv) else $error("resv");
  c_rst: cover property (SUPPLY_RST_REQ);
  c_irq: cover property (SUPPLY_LOW_IRQ);
  c_crd: cover property (CAUSE_RD && SUPPLY_RESET_CAUSE_FLAG);
endmodule // svm_monitor

bind svm_supply_monitor svm_monitor u_mon (.*);

// >>> dv/tb_top.sv
// self-checking bench for the supply monitor
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS, RST_B, POWER_ON_CLEAR, WATCHDOG_RESET, SUPPLY_BELOW;
  logic REG_BYTE_WR, REG_BIT_WR, REG_BIT_VAL, REG_RD, CAUSE_RD;
  logic MASK_WR, MASK_WDATA, SUPPLY_IRQ_MASK, SUPPLY_LOW_IRQ;
  logic SUPPLY_RST_REQ, SUPPLY_RESET_CAUSE_FLAG;
  logic COMPARATOR_ON, COMPARATOR_READY;
  logic [15:0] REG_ADDR;
  logic [7:0]  REG_WDATA, REG_RDATA;
  logic [2:0]  REG_BIT_SEL;
  int          err_count, samples_checked, cyc;
  svm_supply_monitor #(.WARMUP_CYCLES(8)) DUT (.*);
  // clock
  initial begin
    CLK_SYS = 1'h0;
    forever #50 CLK_SYS = ~CLK_SYS;
  end
  // hang guard
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      summarize();
    end
  end
  task summarize();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge CLK_SYS);
  endtask
  // each access lets one idle edge pass so strobes never retoggle at once
  task wr(input logic [15:0] a, input logic [7:0] d);
    REG_ADDR = a; REG_WDATA = d; REG_BYTE_WR = 1'h1; tick(1);
    REG_BYTE_WR = 1'h0; tick(1);
  endtask
  task bwr(input logic [2:0] s, input logic v);
    REG_ADDR = 16'hFF78; REG_BIT_SEL = s; REG_BIT_VAL = v;
    REG_BIT_WR = 1'h1; tick(1);
    REG_BIT_WR = 1'h0; tick(1);
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    REG_ADDR = a; REG_RD = 1'h1; tick(1);
    REG_RD = 1'h0;
    chk(REG_RDATA, e);
    tick(1);
  endtask
  // main sequence, inputs move on the falling edge
  initial begin
    {RST_B, POWER_ON_CLEAR, WATCHDOG_RESET, SUPPLY_BELOW, REG_BYTE_WR} = '0;
    {REG_BIT_WR, REG_BIT_VAL, REG_RD, CAUSE_RD, MASK_WR, MASK_WDATA} = '0;
    REG_ADDR = 16'hFF78; REG_WDATA = 8'h00; REG_BIT_SEL = 3'h0;
    tick(6);
    RST_B = 1'h1;
    chk(8'(SUPPLY_IRQ_MASK), 8'h01);
    rd(16'hFF78, 8'h00);
    // reset mode start: masked, enable, wait, confirm, then select
    wr(16'hFF78, 8'hFD);
    tick(6);
    chk(8'(COMPARATOR_READY), 8'h00);
    tick(2);
    chk(8'(COMPARATOR_READY), 8'h01);
    rd(16'hFF78, 8'h80);
    bwr(3'h1, 1'h1);
    rd(16'hFF78, 8'h82);
    tick(10);
    chk(8'(SUPPLY_RST_REQ), 8'h00);
    SUPPLY_BELOW = 1'h1;
    tick(10);
    chk(8'({SUPPLY_RST_REQ, SUPPLY_LOW_IRQ}), 8'h02);
    rd(16'hFF78, 8'h83);
    chk(8'(SUPPLY_RESET_CAUSE_FLAG), 8'h01);
    // stop reset mode bit by bit: mode first, then enable
    bwr(3'h1, 1'h0);
    bwr(3'h7, 1'h0);
    tick(2);
    rd(16'hFF78, 8'h00);
    chk(8'({SUPPLY_RST_REQ, SUPPLY_LOW_IRQ}), 8'h00);
    // enabling with the supply low raises the request at once
    bwr(3'h7, 1'h1);
    tick(2);
    chk(8'(SUPPLY_LOW_IRQ), 8'h01);
    // watchdog clears the settings but keeps the cause flag
    WATCHDOG_RESET = 1'h1; tick(1);
    WATCHDOG_RESET = 1'h0; tick(2);
    rd(16'hFF78, 8'h00);
    chk(8'({SUPPLY_RST_REQ, SUPPLY_RESET_CAUSE_FLAG}), 8'h01);
    CAUSE_RD = 1'h1; tick(1);
    CAUSE_RD = 1'h0;
    chk(8'(SUPPLY_RESET_CAUSE_FLAG), 8'h00);
    // interrupt mode start: mask, enable, wait, confirm, unmask
    SUPPLY_BELOW = 1'h0;
    MASK_WDATA = 1'h1; MASK_WR = 1'h1; tick(1);
    MASK_WR = 1'h0;
    wr(16'hFF78, 8'h80);
    tick(10);
    rd(16'hFF78, 8'h80);
    MASK_WDATA = 1'h0; MASK_WR = 1'h1; tick(1);
    MASK_WR = 1'h0;
    chk(8'(SUPPLY_IRQ_MASK), 8'h00);
    SUPPLY_BELOW = 1'h1;
    tick(10);
    chk(8'({SUPPLY_RST_REQ, SUPPLY_LOW_IRQ}), 8'h01);
    rd(16'hFF78, 8'h81);
    chk(8'(SUPPLY_RESET_CAUSE_FLAG), 8'h00);
    // stop interrupt mode by clearing only the enable bit
    bwr(3'h7, 1'h0);
    tick(2);
    rd(16'hFF78, 8'h00);
    chk(8'({SUPPLY_RST_REQ, SUPPLY_LOW_IRQ}), 8'h00);
    // reset mode again, then power-on clear wipes settings and cause
    SUPPLY_BELOW = 1'h0;
    wr(16'hFF78, 8'h80);
    tick(10);
    rd(16'hFF78, 8'h80);
    bwr(3'h1, 1'h1);
    SUPPLY_BELOW = 1'h1;
    tick(10);
    chk(8'(SUPPLY_RESET_CAUSE_FLAG), 8'h01);
    POWER_ON_CLEAR = 1'h1; tick(1);
    POWER_ON_CLEAR = 1'h0;
    chk(8'(SUPPLY_RESET_CAUSE_FLAG), 8'h00);
    tick(1);
    rd(16'hFF78, 8'h00);
    SUPPLY_BELOW = 1'h0;
    wr(16'hFF79, 8'h80);
    rd(16'hFF79, 8'h00);
    rd(16'hFF78, 8'h00);
    // mid-run external reset masks the interrupt again
    RST_B = 1'h0; tick(2);
    RST_B = 1'h1;
    chk(8'(SUPPLY_IRQ_MASK), 8'h01);
    summarize();
  end
endmodule // tb_top
